/* File: logic/adc_ctrl_defines.vh */
// Register map, field positions and reset values of the converter control.
// Assumes inclusion by bare name from design files.
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// Register offsets (byte addresses)
`define ADC_IN_BASE_OFS   8'h00
`define ADC_IN6_OFS       8'h18
`define ADC_IN7_OFS       8'h1C
`define ADC_GLOBAL_OFS    8'h20

// Per-input control fields
`define ADC_IN_EN_BIT     0
`define ADC_IN_DEST_HI    31
`define ADC_IN_DEST_LO    8

// Global control fields
`define ADC_G_EN_BIT      0
`define ADC_G_CAL_BIT     1
`define ADC_G_SPP_HI      15
`define ADC_G_SPP_LO      8
`define ADC_G_SIZE_HI     17
`define ADC_G_SIZE_LO     16
`define ADC_G_DROP_BIT    24

// Reset values
`define ADC_SIZE_RST      2'h1
`define ADC_SPP_RST       8'h01

// Size codes
`define ADC_SIZE_8        2'h0
`define ADC_SIZE_16       2'h1
`define ADC_SIZE_32       2'h3

// Calibration pulses after enable
`define ADC_CAL_PULSES    3'h6

`endif

/* File: logic/adc_sample_packetizer_control.v */
// Converter control: per-input routing, sample sizing and packet framing.
// Assumes a conversion front end on the same clock and a byte stream sink.
// Operation
// - Input bits 31:8 hold upper 24 bits of destination endpoint, reset 0.
// - Input control bit 0 enables input, reset 0; bits 7:1 read zero.
// - Global bit 24 flags a dropped sample; a read of global clears it.
// - Size field 17:16 picks width, left aligned; 0 is 8 bit; resets to 1.
// - Size 16: four low zero bits, most significant byte first.
// - Size 3: 32 bit word, twenty low zero bits, MSB first.
// - Global bits 15:8 give samples per packet, reset to 1.
// - Samples per packet 0 keeps packet open until a register access made while idle.
// - Global bit 1 selects internal 0.8V reference for calibration, reset 0.
// - Global bit 0 enables, reset 0; input registers then read-only.
// - No packets for six pulses after enable; seventh onward delivers.
// - Each sample clock rising edge while enabled converts the next enabled input at 12 bits.
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_defines.vh"
module adc_sample_packetizer_control #(
  parameter N_IN = 8
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // Register port, full 32-bit words
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  // Sample clock pin
  input  wire        sample_clk_pin,
  // Conversion front end
  output reg  [2:0]  conv_sel,
  output reg         conv_start,
  output wire        conv_cal_ref,
  input  wire        conv_done,
  input  wire [11:0] conv_data,
  // Byte stream to endpoints
  output reg         st_valid,
  input  wire        st_ready,
  output reg  [7:0]  st_data,
  output reg  [23:0] st_dest,
  output reg         st_end
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  wire [N_IN-1:0]    in_en_q;
  wire [23:0]        in_dest_q [0:N_IN-1];
  reg                g_en_q;
  reg                g_cal_q;
  reg  [7:0]         g_spp_q;
  reg  [1:0]         g_size_q;
  reg                drop_q;
  reg  [2:0]         cal_cnt_q;
  reg  [2:0]         smp_clk_q;
  reg  [2:0]         cur_q;
  reg  [31:0]        shift_q;
  reg  [1:0]         bytes_q;
  reg                busy_q;
  reg  [7:0]         pkt_cnt_q;
  reg                open_q;
  reg  [23:0]        open_dest_q;
  reg                pend_sel_q;

  wire g_hit = (reg_addr == `ADC_GLOBAL_OFS);
  wire in_hit = (reg_addr[7:5] == 3'h0) && (reg_addr[1:0] == 2'h0);
  wire [2:0] in_idx = reg_addr[4:2];
  wire acc = reg_wr | reg_rd;

  function [2:0] next_in;
    input [2:0]      from;
    input [N_IN-1:0] en;
    integer          k;
    reg              found;
    reg   [2:0]      c;
    begin
      next_in = from;
      found = 1'b0;
      for (k = 1; k <= N_IN; k = k + 1) begin
        c = from + k[2:0];
        if (!found && en[c]) begin
          next_in = c;
          found = 1'b1;
        end
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // Sample clock pin sync and edge
  // ------------------------------------------------------------------
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      smp_clk_q <= 3'h0;
    end else begin
      smp_clk_q <= {smp_clk_q[1:0], sample_clk_pin};
    end
  end
  wire smp_rise = smp_clk_q[1] & ~smp_clk_q[2];

  assign conv_cal_ref = g_cal_q;

  // ------------------------------------------------------------------
  // Register writes and reads
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_in
      reg        en_q;
      reg [23:0] dest_q;
      wire       wr_hit = reg_wr && in_hit && ({29'h0, in_idx} == gi);
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          en_q   <= 1'b0;
          dest_q <= 24'h0000;
        end else if (wr_hit && !g_en_q) begin
          en_q   <= reg_wdata[`ADC_IN_EN_BIT];
          dest_q <= reg_wdata[`ADC_IN_DEST_HI:`ADC_IN_DEST_LO];
        end
      end
      assign in_en_q[gi]   = en_q;
      assign in_dest_q[gi] = dest_q;
    end
  endgenerate

  wire close_now = acc && open_q && !busy_q && (g_spp_q == 8'h00);
  wire drop_evt  = conv_done && pend_sel_q && (busy_q || close_now);

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      g_en_q   <= 1'b0;
      g_cal_q  <= 1'b0;
      g_spp_q  <= `ADC_SPP_RST;
      g_size_q <= `ADC_SIZE_RST;
      drop_q   <= 1'b0;
    end else begin
      if (reg_wr && g_hit) begin
        g_en_q   <= reg_wdata[`ADC_G_EN_BIT];
        g_cal_q  <= reg_wdata[`ADC_G_CAL_BIT];
        g_spp_q  <= reg_wdata[`ADC_G_SPP_HI:`ADC_G_SPP_LO];
        g_size_q <= reg_wdata[`ADC_G_SIZE_HI:`ADC_G_SIZE_LO];
      end
      if (drop_evt)
        drop_q <= 1'b1;
      else if (reg_rd && g_hit)
        drop_q <= 1'b0;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (g_hit)
        reg_rdata <= {7'h00, drop_q, 6'h00, g_size_q, g_spp_q,
                      6'h00, g_cal_q, g_en_q};
      else if (in_hit)
        reg_rdata <= {in_dest_q[in_idx], 7'h00, in_en_q[in_idx]};
      else
        reg_rdata <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------------
  // Sequencing, calibration skip and sample formatting
  // ------------------------------------------------------------------
  wire en_rise = reg_wr && g_hit && reg_wdata[`ADC_G_EN_BIT] && !g_en_q;
  wire pkt_full = (g_spp_q != 8'h00) && (pkt_cnt_q + 8'h01 == g_spp_q);
  wire last_byte = st_valid && st_ready && (bytes_q == 2'h0);

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cal_cnt_q   <= 3'h0;
      cur_q       <= 3'h7;
      conv_sel    <= 3'h0;
      conv_start  <= 1'b0;
      pend_sel_q  <= 1'b0;
      shift_q     <= 32'h0000_0000;
      bytes_q     <= 2'h0;
      busy_q      <= 1'b0;
      st_valid    <= 1'b0;
      st_data     <= 8'h00;
      st_dest     <= 24'h0000;
      st_end      <= 1'b0;
      pkt_cnt_q   <= 8'h00;
      open_q      <= 1'b0;
      open_dest_q <= 24'h0000;
    end else begin
      conv_start <= 1'b0;
      if (en_rise)
        cal_cnt_q <= `ADC_CAL_PULSES;
      if (g_en_q && smp_rise && in_en_q != {N_IN{1'b0}}) begin
        cur_q      <= next_in(cur_q, in_en_q);
        conv_sel   <= next_in(cur_q, in_en_q);
        conv_start <= 1'b1;
        if (cal_cnt_q != 3'h0)
          cal_cnt_q <= cal_cnt_q - 3'h1;
        pend_sel_q <= (cal_cnt_q == 3'h0);
      end
      // Sample accepted only when idle and calibration done
      if (conv_done && !busy_q && pend_sel_q && !close_now) begin
        busy_q  <= 1'b1;
        st_dest <= in_dest_q[conv_sel];
        case (g_size_q)
          `ADC_SIZE_8: begin
            shift_q <= {conv_data[11:4], 24'h00_0000};
            bytes_q <= 2'h0;
          end
          `ADC_SIZE_32: begin
            shift_q <= {conv_data, 20'h0_0000};
            bytes_q <= 2'h3;
          end
          default: begin
            shift_q <= {conv_data, 4'h0, 16'h0000};
            bytes_q <= 2'h1;
          end
        endcase
        st_valid <= 1'b1;
        st_data  <= conv_data[11:4];
        st_end   <= (g_size_q == `ADC_SIZE_8) && pkt_full;
        if (open_q && open_dest_q != in_dest_q[conv_sel])
          pkt_cnt_q <= 8'h00;
        open_q      <= 1'b1;
        open_dest_q <= in_dest_q[conv_sel];
      end else if (st_valid && st_ready) begin
        if (bytes_q != 2'h0) begin
          shift_q  <= {shift_q[23:0], 8'h00};
          st_data  <= shift_q[23:16];
          bytes_q  <= bytes_q - 2'h1;
          st_end   <= (bytes_q == 2'h1) && pkt_full;
        end else begin
          st_valid <= 1'b0;
          st_end   <= 1'b0;
          busy_q   <= 1'b0;
          if (pkt_full) begin
            pkt_cnt_q <= 8'h00;
            open_q    <= 1'b0;
          end else begin
            pkt_cnt_q <= pkt_cnt_q + 8'h01;
          end
        end
      end
      // Open packet closed by a register access while idle when samples per packet is 0
      if (close_now) begin
        st_valid  <= 1'b1;
        st_dest   <= open_dest_q;
        st_end    <= 1'b1;
        st_data   <= 8'h00;
        bytes_q   <= 2'h0;
        busy_q    <= 1'b1;
        open_q    <= 1'b0;
        pkt_cnt_q <= 8'h00;
      end
      if (last_byte && !open_q && g_spp_q == 8'h00)
        pkt_cnt_q <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* File: sim/adc_ctrl_checker.sv */
// Assertions on the converter control's register and stream ports.
// Assumes the top module's port names; bound after the module.
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl_checker (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Converter and stream
  input wire logic        conv_start,
  input wire logic        conv_cal_ref,
  input wire logic        conv_done,
  input wire logic        st_valid,
  input wire logic        st_ready,
  input wire logic [7:0]  st_data,
  input wire logic [23:0] st_dest,
  input wire logic        st_end
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_stream_hold: assert property (st_valid && !st_ready |=>
    st_valid && $stable({st_data, st_dest, st_end})) else $error("stall moved");
  a_cal_ref: assert property (reg_wr && reg_addr == 8'h20 |=>
    conv_cal_ref == $past(reg_wdata[1])) else $error("reference select");
  a_in_reserved: assert property (reg_rd && reg_addr[7:3] == 5'h03 |=>
    reg_rdata[7:1] == 7'h00) else $error("input reserved bits");
  a_glob_reserved: assert property (reg_rd && reg_addr == 8'h20 |=>
    {reg_rdata[31:25], reg_rdata[23:18], reg_rdata[7:2]} == 19'h0)
    else $error("global reserved bits");
  a_drop_clear: assert property (!conv_done ##1 (reg_rd &&
    reg_addr == 8'h20 && !conv_done)[*2] |=> !reg_rdata[24])
    else $error("drop flag kept");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h20 |=>
    reg_rdata == 32'h0) else $error("unmapped read");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start too long");
  a_glob_rw: assert property (reg_wr && reg_addr == 8'h20 ##1 reg_rd &&
    reg_addr == 8'h20 |=> reg_rdata[17:8] == $past(reg_wdata[17:8], 2))
    else $error("global fields");
  cover property (st_valid && st_ready && st_end);
  cover property (st_valid && !st_ready);
  cover property (conv_cal_ref);
endmodule
bind adc_sample_packetizer_control adc_ctrl_checker i_chk (.*);
`default_nettype wire

/* File: sim/adc_far_model.sv */
// Far side: conversion front end and endpoint sink.
// Assumes the control's clock; mode 0 prompt, 1 every other cycle, 2 stuck.
`timescale 1ns/1ns
`default_nettype none
module adc_far_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Front end
  input  wire logic        conv_start,
  input  wire logic [2:0]  conv_sel,
  output var  logic        conv_done,
  output var  logic [11:0] conv_data,
  // Sink
  input  wire logic [1:0]  mode,
  output var  logic        st_ready
);
  logic tick_q;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      conv_done <= 1'b0;
      conv_data <= 12'h000;
      tick_q    <= 1'b0;
    end else begin
      conv_done <= conv_start;
      conv_data <= conv_start ? {conv_sel, 9'h15A} : ~conv_data;
      tick_q    <= ~tick_q;
    end
  end
  always @* st_ready = (mode == 2'd0) || (mode == 2'd1 && tick_q);
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Bench: register access, sizing, framing, locking and drop flag.
// Assumes the far side model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        sample_clk_pin = 1'b0, conv_start, conv_cal_ref, conv_done;
  logic        st_valid, st_ready, st_end;
  logic [7:0]  reg_addr = 8'h00, st_data;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, w;
  logic [2:0]  conv_sel;
  logic [11:0] conv_data;
  logic [23:0] st_dest;
  logic [1:0]  mode = 2'd0, sz;
  logic [7:0]  spp;
  logic [32:0] got[$], exp_q[$];
  int          err_count = 0, num_checks = 0, cyc = 0, nb;
  adc_sample_packetizer_control i_adc_sample_packetizer_control (.*);
  adc_far_model i_adc_far_model (.*);
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (st_valid && st_ready) got.push_back({st_end, st_dest, st_data});
    if (cyc == 5000) begin
      err_count++;
      close_out;
    end
  end
  task check(string n, logic [32:0] e, logic [32:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task acc(logic wr, logic rd, logic [7:0] a, logic [31:0] d);
    reg_wr = wr;
    reg_rd = rd;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
  endtask
  task rd(string n, logic [7:0] a, logic [31:0] e);
    acc(1'b0, 1'b1, a, 32'h0);
    check(n, {1'b0, e}, {1'b0, reg_rdata});
  endtask
  task pulse(int n);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (n) begin
      sample_clk_pin = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 sample_clk_pin = 1'b0;
      repeat (10) @(posedge sys_clk);
      #1;
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1'b1;
    rd("global reset", 8'h20, 32'h0001_0100);
    rd("in6 reset", 8'h18, 32'h0);
    acc(1'b1, 1'b0, 8'h18, 32'hABCD_EFFF);
    rd("in6 fields", 8'h18, 32'hABCD_EF01);
    acc(1'b1, 1'b0, 8'h1C, 32'h1234_5600);
    rd("unmapped", 8'h24, 32'h0);
    for (int k = 0; k < 4; k++) begin
      sz = (k == 1) ? 2'h1 : (k == 2) ? 2'h3 : 2'h0;
      spp = (k == 3) ? 8'h00 : 8'h02;
      nb = (sz == 2'h0) ? 1 : (sz == 2'h1) ? 2 : 4;
      mode = k[0] ? 2'd1 : 2'd0;
      acc(1'b1, 1'b0, 8'h20, 32'h0);
      acc(1'b1, 1'b0, 8'h20, {14'h0, sz, spp, 8'h01});
      rd("global cfg", 8'h20, {14'h0, sz, spp, 8'h01});
      got.delete();
      pulse(6);
      check("quiet", 33'h0, 33'(got.size()));
      pulse(2);
      if (spp == 8'h00) rd("global", 8'h20, {14'h0, sz, spp, 8'h01});
      repeat (8) acc(1'b0, 1'b0, 8'h20, 32'h0);
      exp_q.delete();
      w = {12'hD5A, 20'h0};
      for (int s = 0; s < 2; s++)
        for (int b = 0; b < nb; b++)
          exp_q.push_back({spp != 0 && s == 1 && b == nb - 1, 24'hABCDEF,
                           w[31 - 8 * b -: 8]});
      if (spp == 8'h00) exp_q.push_back({1'b1, 24'hABCDEF, 8'h00});
      check("byte count", 33'(exp_q.size()), 33'(got.size()));
      for (int i = 0; i < exp_q.size(); i++)
        check("stream byte", exp_q[i], got[i]);
    end
    acc(1'b1, 1'b0, 8'h18, 32'h0);
    rd("in6 locked", 8'h18, 32'hABCD_EF01);
    acc(1'b1, 1'b0, 8'h20, 32'h0001_0103);
    check("cal ref", 33'h1, {32'h0, conv_cal_ref});
    mode = 2'd2;
    pulse(3);
    acc(1'b0, 1'b1, 8'h20, 32'h0);
    check("drop set", 33'h1, {32'h0, reg_rdata[24]});
    acc(1'b0, 1'b1, 8'h20, 32'h0);
    check("drop clear", 33'h0, {32'h0, reg_rdata[24]});
    mode = 2'd0;
    acc(1'b0, 1'b0, 8'h20, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
